// File: src/malu_pkg.sv
// package: opcodes, widths and status layout for the skip/table alu block
package malu_pkg;
  localparam int DW = 8;
  localparam int PW = 14;
  localparam int PAW = 11;
  localparam int PAGE_LSB = 8;
  localparam logic [7:0] ALL_ONES = 8'hff;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [7:0] ONE_BYTE = 8'h01;
  localparam logic [2:0] LAST_PAGE = 3'h7;
  localparam logic [3:0] FLAGS_RST = 4'h0;
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [5:0] TBH_RST = 6'h00;
  // operation codes
  typedef enum logic [4:0] {
    MALU_NOP = 5'h00,
    MALU_DEC_ACC_SKZ = 5'h01,
    MALU_SET_BYTE = 5'h02,
    MALU_SET_BIT = 5'h03,
    MALU_INC_SKZ = 5'h04,
    MALU_INC_ACC_SKZ = 5'h05,
    MALU_SKIP_BIT_NZ = 5'h06,
    MALU_SUB_MEM = 5'h07,
    MALU_SUB_TO_MEM = 5'h08,
    MALU_SUB_IMM = 5'h09,
    MALU_SWAP = 5'h0a,
    MALU_SWAP_ACC = 5'h0b,
    MALU_SKIP_ZERO = 5'h0c,
    MALU_MOVE_ACC_SKZ = 5'h0d,
    MALU_SKIP_BIT_Z = 5'h0e,
    MALU_TAB_CUR = 5'h0f,
    MALU_TAB_LAST = 5'h10,
    MALU_XOR_MEM = 5'h11,
    MALU_XOR_TO_MEM = 5'h12,
    MALU_XOR_IMM = 5'h13
  } malu_op_t;
  // status flags: overflow, zero, aux carry, carry
  typedef struct packed {
    logic ov;
    logic z;
    logic ac;
    logic c;
  } malu_flags_t;
  // one decoded instruction from the sequencer
  typedef struct packed {
    logic valid;
    malu_op_t op;
    logic [7:0] lit;
    logic [2:0] bitsel;
  } malu_instr_t;
  // sequencing state
  typedef enum logic [1:0] {
    MALU_RUN,
    MALU_TAB_WAIT,
    MALU_DUMMY
  } malu_state_t;
  // all block state
  typedef struct packed {
    malu_state_t st;
    logic [7:0] acc;
    malu_flags_t fl;
    logic [5:0] tbh;
    logic mem_we;
    logic [7:0] mem_wd;
    logic [PAW-1:0] rom_addr;
    logic rom_re;
    logic discard;
    logic busy;
  } malu_state_s_t;
endpackage

// File: src/malu_core.sv
// execution unit for skip, set, subtract, swap, xor and table-read ops
// Contract
// - decrement-to-acc: acc gets byte minus one, memory kept, skip on zero
// - taken skip discards prefetched instruction, adds one dummy cycle
// - byte set writes ff to memory, flags untouched
// - bit set forces only the selected bit to one
// - increment writes byte plus one back, skips when it wraps to zero
// - increment-to-acc loads byte plus one, memory kept, skip on zero
// - bit-nonzero test skips when selected bit is one, changes nothing
// - subtract memory: acc plus inverted byte plus one, sets ov z ac c
// - subtract-to-memory writes same difference back to memory, same flags
// - subtract literal from acc, result in acc, sets ov z ac c
// - swap exchanges nibbles of the byte in place, flags untouched
// - swap-to-acc puts swapped byte in acc, memory kept
// - byte-zero test skips when byte is zero, changes nothing
// - move-and-test copies byte to acc, skips when it is zero
// - bit-zero test skips when selected bit is clear, same timing
// - current-page table read: low byte to memory, high part to latch
// - last-page table read uses final program page instead
// - xor with memory leaves result in acc, only zero flag changes
// - xor-to-memory writes result to memory, updates zero flag
// - xor literal into acc, updates zero flag
//
`timescale 1ns/1ps
module malu_core import malu_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire malu_instr_t instr_i,
  input wire logic [7:0] mem_rd_i,
  input wire logic [7:0] table_pointer_i,
  input wire logic [PAW-1:0] pc_i,
  input wire logic [PW-1:0] rom_data_i,
  output logic mem_we_o,
  output logic [7:0] mem_wd_o,
  output logic [PAW-1:0] rom_addr_o,
  output logic rom_re_o,
  output logic [7:0] accumulator_reg_o,
  output logic overflow_flag_o,
  output logic zero_flag_o,
  output logic aux_carry_flag_o,
  output logic carry_flag_o,
  output logic [5:0] table_high_latch_o,
  output logic discard_o,
  output logic busy_o
);
  malu_state_s_t s_r;
  malu_state_s_t s_nxt;
  logic [7:0] b;
  logic [7:0] sub_src;
  logic [8:0] sum;
  logic [4:0] lo_sum;
  logic [7:0] inc_v;
  logic [7:0] dec_v;
  logic [7:0] swp_v;
  logic [7:0] bitmask;
  logic skip;

  // shared datapath terms
  always_comb begin
    b = mem_rd_i;
    inc_v = b + ONE_BYTE;
    dec_v = b - ONE_BYTE;
    swp_v = {b[3:0], b[7:4]};
    bitmask = ONE_BYTE << instr_i.bitsel;
    sub_src = (instr_i.op == MALU_SUB_IMM) ? instr_i.lit : b;
    sum = {1'b0, s_r.acc} + {1'b0, ~sub_src} + 9'h001;
    lo_sum = {1'b0, s_r.acc[3:0]} + {1'b0, ~sub_src[3:0]} + 5'h01;
  end

  // next-state logic
  always_comb begin
    s_nxt = s_r;
    s_nxt.mem_we = 1'b0;
    s_nxt.rom_re = 1'b0;
    s_nxt.discard = 1'b0;
    s_nxt.busy = 1'b0;
    skip = 1'b0;
    case (s_r.st)
      MALU_RUN: begin
        if (instr_i.valid) begin
          case (instr_i.op)
            MALU_DEC_ACC_SKZ: begin
              s_nxt.acc = dec_v;
              skip = (dec_v == ZERO_BYTE);
            end
            MALU_SET_BYTE: begin
              s_nxt.mem_we = 1'b1;
              s_nxt.mem_wd = ALL_ONES;
            end
            MALU_SET_BIT: begin
              s_nxt.mem_we = 1'b1;
              s_nxt.mem_wd = b | bitmask;
            end
            MALU_INC_SKZ: begin
              s_nxt.mem_we = 1'b1;
              s_nxt.mem_wd = inc_v;
              skip = (inc_v == ZERO_BYTE);
            end
            MALU_INC_ACC_SKZ: begin
              s_nxt.acc = inc_v;
              skip = (inc_v == ZERO_BYTE);
            end
            MALU_SKIP_BIT_NZ: skip = |(b & bitmask);
            MALU_SUB_MEM, MALU_SUB_IMM, MALU_SUB_TO_MEM: begin
              if (instr_i.op == MALU_SUB_TO_MEM) begin
                s_nxt.mem_we = 1'b1;
                s_nxt.mem_wd = sum[7:0];
              end else begin
                s_nxt.acc = sum[7:0];
              end
              s_nxt.fl.c = sum[8];
              s_nxt.fl.ac = lo_sum[4];
              s_nxt.fl.z = (sum[7:0] == ZERO_BYTE);
              s_nxt.fl.ov = (s_r.acc[7] != sub_src[7]) && (sum[7] != s_r.acc[7]);
            end
            MALU_SWAP: begin
              s_nxt.mem_we = 1'b1;
              s_nxt.mem_wd = swp_v;
            end
            MALU_SWAP_ACC: s_nxt.acc = swp_v;
            MALU_SKIP_ZERO: skip = (b == ZERO_BYTE);
            MALU_MOVE_ACC_SKZ: begin
              s_nxt.acc = b;
              skip = (b == ZERO_BYTE);
            end
            MALU_SKIP_BIT_Z: skip = ~|(b & bitmask);
            MALU_TAB_CUR, MALU_TAB_LAST: begin
              // page from pc upper bits or the last page, offset from pointer
              s_nxt.rom_addr = (instr_i.op == MALU_TAB_LAST) ?
                {LAST_PAGE, table_pointer_i} :
                {pc_i[PAW-1:PAGE_LSB], table_pointer_i};
              s_nxt.rom_re = 1'b1;
              s_nxt.busy = 1'b1;
              s_nxt.st = MALU_TAB_WAIT;
            end
            MALU_XOR_MEM, MALU_XOR_IMM: begin
              s_nxt.acc = s_r.acc ^ ((instr_i.op == MALU_XOR_IMM) ? instr_i.lit : b);
              s_nxt.fl.z = (s_nxt.acc == ZERO_BYTE);
            end
            MALU_XOR_TO_MEM: begin
              s_nxt.mem_we = 1'b1;
              s_nxt.mem_wd = s_r.acc ^ b;
              s_nxt.fl.z = ((s_r.acc ^ b) == ZERO_BYTE);
            end
            default: ;
          endcase
          if (skip) begin
            s_nxt.discard = 1'b1;
            s_nxt.busy = 1'b1;
            s_nxt.st = MALU_DUMMY;
          end
        end
      end
      MALU_TAB_WAIT: begin
        // rom word valid now: low byte to memory, rest to latch
        s_nxt.mem_we = 1'b1;
        s_nxt.mem_wd = rom_data_i[7:0];
        s_nxt.tbh = rom_data_i[PW-1:8];
        s_nxt.st = MALU_RUN;
      end
      MALU_DUMMY: s_nxt.st = MALU_RUN;
      default: s_nxt.st = MALU_RUN;
    endcase
  end

  // state register
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_r <= '{st: MALU_RUN, acc: ACC_RST, fl: FLAGS_RST, tbh: TBH_RST,
               mem_we: 1'b0, mem_wd: ZERO_BYTE, rom_addr: '0, rom_re: 1'b0,
               discard: 1'b0, busy: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from state
  assign mem_we_o = s_r.mem_we;
  assign mem_wd_o = s_r.mem_wd;
  assign rom_addr_o = s_r.rom_addr;
  assign rom_re_o = s_r.rom_re;
  assign accumulator_reg_o = s_r.acc;
  assign overflow_flag_o = s_r.fl.ov;
  assign zero_flag_o = s_r.fl.z;
  assign aux_carry_flag_o = s_r.fl.ac;
  assign carry_flag_o = s_r.fl.c;
  assign table_high_latch_o = s_r.tbh;
  assign discard_o = s_r.discard;
  assign busy_o = s_r.busy;

  // assertions
  logic run_v;
  assign run_v = instr_i.valid && (s_r.st == MALU_RUN);

  sequence skip_seq;
    discard_o && busy_o ##1 (s_r.st == MALU_RUN) && !discard_o;
  endsequence

  a_skip_dummy: assert property (@(posedge clk_i) disable iff (rst_i)
    run_v && skip |=> skip_seq) else $error("skip did not take one dummy cycle");
  a_dec_to_acc: assert property (@(posedge clk_i) disable iff (rst_i)
    run_v && instr_i.op == MALU_DEC_ACC_SKZ |=>
      accumulator_reg_o == $past(mem_rd_i) - 8'h01 && !mem_we_o)
    else $error("decrement to acc wrong");
  a_set_byte: assert property (@(posedge clk_i) disable iff (rst_i)
    run_v && instr_i.op == MALU_SET_BYTE |=> mem_we_o && mem_wd_o == 8'hff && $stable(s_r.fl))
    else $error("byte set wrong");
  a_set_bit: assert property (@(posedge clk_i) disable iff (rst_i)
    run_v && instr_i.op == MALU_SET_BIT |=>
      mem_wd_o == ($past(mem_rd_i) | (8'h01 << $past(instr_i.bitsel))))
    else $error("bit set wrong");
  a_inc_wrap: assert property (@(posedge clk_i) disable iff (rst_i)
    run_v && instr_i.op == MALU_INC_SKZ && mem_rd_i == 8'hff |=> discard_o && mem_wd_o == 8'h00)
    else $error("increment wrap did not skip");
  a_bit_nz: assert property (@(posedge clk_i) disable iff (rst_i)
    run_v && instr_i.op == MALU_SKIP_BIT_NZ |=>
      discard_o == $past(mem_rd_i[instr_i.bitsel]) && !mem_we_o && $stable(accumulator_reg_o))
    else $error("bit nonzero test wrong");
  a_sub_carry: assert property (@(posedge clk_i) disable iff (rst_i)
    run_v && instr_i.op == MALU_SUB_MEM |=>
      carry_flag_o == ($past(accumulator_reg_o) >= $past(mem_rd_i)))
    else $error("subtract carry wrong");
  a_table_read: assert property (@(posedge clk_i) disable iff (rst_i)
    run_v && instr_i.op == MALU_TAB_CUR |=> rom_re_o ##1 mem_we_o &&
      mem_wd_o == $past(rom_data_i[7:0]) && table_high_latch_o == $past(rom_data_i[13:8]))
    else $error("table read wrong");
  a_xor_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    run_v && instr_i.op == MALU_XOR_MEM |=>
      zero_flag_o == (accumulator_reg_o == 8'h00) && $stable(carry_flag_o))
    else $error("xor zero flag wrong");

  // table read steps: fetch cycle, then store cycle
  sequence tab_fetch_seq;
    rom_re_o && busy_o && !mem_we_o;
  endsequence
  sequence tab_store_seq;
    mem_we_o && !busy_o && (s_r.st == MALU_RUN);
  endsequence

  // decrement form never writes memory, skips only on one
  a_dec_keep_mem: assert property (@(posedge clk_i) disable iff (rst_i)
    run_v && instr_i.op == MALU_DEC_ACC_SKZ |=>
      !mem_we_o && discard_o == ($past(mem_rd_i) == 8'h01))
    else $error("decrement to acc touched memory or skip wrong");

  // untaken skip and plain ops finish in one cycle
  a_no_skip_one: assert property (@(posedge clk_i) disable iff (rst_i)
    run_v && !skip && instr_i.op != MALU_TAB_CUR && instr_i.op != MALU_TAB_LAST |=>
      !discard_o && !busy_o)
    else $error("single cycle op took a dummy cycle");

  // dummy cycle ignores whatever is presented
  a_dummy_refuse: assert property (@(posedge clk_i) disable iff (rst_i)
    s_r.st == MALU_DUMMY |=>
      !mem_we_o && !discard_o && $stable(accumulator_reg_o))
    else $error("instruction taken during dummy cycle");

  // discard is a one cycle pulse
  a_discard_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    discard_o |=>
      !discard_o)
    else $error("discard longer than one cycle");

  // byte set keeps acc and never skips
  a_set_byte_acc: assert property (@(posedge clk_i) disable iff (rst_i)
    run_v && instr_i.op == MALU_SET_BYTE |=>
      $stable(accumulator_reg_o) && !discard_o)
    else $error("byte set changed acc");

  // bit set writes and keeps the ov, z and ac flags
  a_set_bit_keep: assert property (@(posedge clk_i) disable iff (rst_i)
    run_v && instr_i.op == MALU_SET_BIT |=>
      mem_we_o && !discard_o && $stable({overflow_flag_o, zero_flag_o, aux_carry_flag_o}))
    else $error("bit set side effect");

  // increment writes byte plus one back
  a_inc_write: assert property (@(posedge clk_i) disable iff (rst_i)
    run_v && instr_i.op == MALU_INC_SKZ |=>
      mem_we_o && mem_wd_o == $past(mem_rd_i) + 8'h01 && $stable(accumulator_reg_o))
    else $error("increment write wrong");

  // increment to acc, memory untouched
  a_inc_to_acc: assert property (@(posedge clk_i) disable iff (rst_i)
    run_v && instr_i.op == MALU_INC_ACC_SKZ |=>
      accumulator_reg_o == $past(mem_rd_i) + 8'h01 && !mem_we_o)
    else $error("increment to acc wrong");

  // increment to acc skips only on wrap
  a_inc_acc_skip: assert property (@(posedge clk_i) disable iff (rst_i)
    run_v && instr_i.op == MALU_INC_ACC_SKZ |=>
      discard_o == ($past(mem_rd_i) == 8'hff))
    else $error("increment to acc skip wrong");

  // skip follows the written result
  a_skip_result: assert property (@(posedge clk_i) disable iff (rst_i)
    run_v && instr_i.op == MALU_INC_SKZ |=>
      discard_o == (mem_wd_o == 8'h00))
    else $error("skip not taken from result");

  // bit-zero test skips on a clear bit
  a_bit_z: assert property (@(posedge clk_i) disable iff (rst_i)
    run_v && instr_i.op == MALU_SKIP_BIT_Z |=>
      discard_o == !$past(mem_rd_i[instr_i.bitsel]) && !mem_we_o)
    else $error("bit zero test wrong");

  // subtract memory result into acc, memory kept
  a_sub_mem_res: assert property (@(posedge clk_i) disable iff (rst_i)
    run_v && instr_i.op == MALU_SUB_MEM |=>
      accumulator_reg_o == $past(accumulator_reg_o) - $past(mem_rd_i) && !mem_we_o)
    else $error("subtract result wrong");

  // subtract aux carry means no borrow out of low nibble
  a_sub_aux: assert property (@(posedge clk_i) disable iff (rst_i)
    run_v && instr_i.op == MALU_SUB_MEM |=>
      aux_carry_flag_o == ($past(accumulator_reg_o[3:0]) >= $past(mem_rd_i[3:0])))
    else $error("subtract aux carry wrong");

  // subtract zero flag follows the acc
  a_sub_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    run_v && instr_i.op == MALU_SUB_MEM |=>
      zero_flag_o == (accumulator_reg_o == 8'h00))
    else $error("subtract zero flag wrong");

  // subtract to memory keeps acc
  a_sub_to_mem: assert property (@(posedge clk_i) disable iff (rst_i)
    run_v && instr_i.op == MALU_SUB_TO_MEM |=>
      mem_we_o && mem_wd_o == $past(accumulator_reg_o) - $past(mem_rd_i) && $stable(accumulator_reg_o))
    else $error("subtract to memory wrong");

  // subtract to memory carry
  a_sub_mem_carry: assert property (@(posedge clk_i) disable iff (rst_i)
    run_v && instr_i.op == MALU_SUB_TO_MEM |=>
      carry_flag_o == ($past(accumulator_reg_o) >= $past(mem_rd_i)))
    else $error("subtract to memory carry wrong");

  // subtract literal result and carry
  a_sub_imm: assert property (@(posedge clk_i) disable iff (rst_i)
    run_v && instr_i.op == MALU_SUB_IMM |=>
      accumulator_reg_o == $past(accumulator_reg_o) - $past(instr_i.lit) && carry_flag_o == ($past(accumulator_reg_o) >= $past(instr_i.lit)))
    else $error("subtract literal wrong");

  // swap in place, zero flag kept
  a_swap_mem: assert property (@(posedge clk_i) disable iff (rst_i)
    run_v && instr_i.op == MALU_SWAP |=>
      mem_we_o && mem_wd_o == {$past(mem_rd_i[3:0]), $past(mem_rd_i[7:4])} && $stable(zero_flag_o))
    else $error("swap wrong");

  // swap into acc, memory kept
  a_swap_acc: assert property (@(posedge clk_i) disable iff (rst_i)
    run_v && instr_i.op == MALU_SWAP_ACC |=>
      accumulator_reg_o == {$past(mem_rd_i[3:0]), $past(mem_rd_i[7:4])} && !mem_we_o)
    else $error("swap to acc wrong");

  // byte-zero test changes nothing
  a_byte_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    run_v && instr_i.op == MALU_SKIP_ZERO |=>
      discard_o == ($past(mem_rd_i) == 8'h00) && !mem_we_o && $stable(accumulator_reg_o))
    else $error("byte zero test wrong");

  // move and test copies and skips on zero
  a_move_test: assert property (@(posedge clk_i) disable iff (rst_i)
    run_v && instr_i.op == MALU_MOVE_ACC_SKZ |=>
      accumulator_reg_o == $past(mem_rd_i) && discard_o == ($past(mem_rd_i) == 8'h00))
    else $error("move and test wrong");

  // fetch always sits in the wait state
  a_table_busy: assert property (@(posedge clk_i) disable iff (rst_i)
    rom_re_o |->
      busy_o && (s_r.st == MALU_TAB_WAIT))
    else $error("table fetch outside wait state");

  // last page address, then store
  a_table_last: assert property (@(posedge clk_i) disable iff (rst_i)
    run_v && instr_i.op == MALU_TAB_LAST |=>
      tab_fetch_seq ##0 (rom_addr_o == {LAST_PAGE, $past(table_pointer_i)}) ##1 tab_store_seq)
    else $error("last page table read wrong");

  // current page from pc, high part to latch
  a_table_page: assert property (@(posedge clk_i) disable iff (rst_i)
    run_v && instr_i.op == MALU_TAB_CUR |=>
      rom_addr_o == {$past(pc_i[PAW-1:PAGE_LSB]), $past(table_pointer_i)} ##1 table_high_latch_o == $past(rom_data_i[PW-1:8]))
    else $error("table page or latch wrong");

  // xor with memory keeps other flags
  a_xor_acc: assert property (@(posedge clk_i) disable iff (rst_i)
    run_v && instr_i.op == MALU_XOR_MEM |=>
      accumulator_reg_o == ($past(accumulator_reg_o) ^ $past(mem_rd_i)) && $stable({overflow_flag_o, aux_carry_flag_o}))
    else $error("xor with memory wrong");

  // xor to memory writes and sets zero
  a_xor_to_mem: assert property (@(posedge clk_i) disable iff (rst_i)
    run_v && instr_i.op == MALU_XOR_TO_MEM |=>
      mem_we_o && mem_wd_o == ($past(accumulator_reg_o) ^ $past(mem_rd_i)) && zero_flag_o == (mem_wd_o == 8'h00))
    else $error("xor to memory wrong");

  // xor literal into acc
  a_xor_imm: assert property (@(posedge clk_i) disable iff (rst_i)
    run_v && instr_i.op == MALU_XOR_IMM |=>
      accumulator_reg_o == ($past(accumulator_reg_o) ^ $past(instr_i.lit)) && zero_flag_o == (accumulator_reg_o == 8'h00))
    else $error("xor literal wrong");
endmodule

// File: dv/testbench.sv
// self-checking bench for the skip, subtract, swap, xor and table-read unit
`timescale 1ns/1ps
module testbench import malu_pkg::*;;
  logic clk_i;
  logic rst_i;
  malu_instr_t instr_i;
  logic [7:0] mem_rd_i;
  logic mem_we_o, rom_re_o, discard_o, busy_o;
  logic [7:0] mem_wd_o, accumulator_reg_o;
  logic [PAW-1:0] rom_addr_o;
  logic overflow_flag_o, zero_flag_o, aux_carry_flag_o, carry_flag_o;
  logic [5:0] table_high_latch_o;
  logic [3:0] ef;
  logic [7:0] ptr_v;
  logic [PAW-1:0] pc_v;
  logic [PW-1:0] rom_v;
  int n_mismatch;
  int n_compared;

  malu_core uut (.clk_i(clk_i), .rst_i(rst_i), .instr_i(instr_i), .mem_rd_i(mem_rd_i),
    .table_pointer_i(ptr_v), .pc_i(pc_v), .rom_data_i(rom_v), .mem_we_o(mem_we_o),
    .mem_wd_o(mem_wd_o), .rom_addr_o(rom_addr_o), .rom_re_o(rom_re_o),
    .accumulator_reg_o(accumulator_reg_o), .overflow_flag_o(overflow_flag_o),
    .zero_flag_o(zero_flag_o), .aux_carry_flag_o(aux_carry_flag_o),
    .carry_flag_o(carry_flag_o), .table_high_latch_o(table_high_latch_o),
    .discard_o(discard_o), .busy_o(busy_o));

  // compare helpers
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t byte got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t bit got %b expected %b", $time, got, exp);
    end
  endtask

  // one instruction, then judge skip, write, acc and flags one cycle later
  task automatic exec(input malu_op_t op, input logic [7:0] rd, lit, input logic [2:0] bs,
      input logic sk, we, input logic [7:0] wd, ea);
    @(posedge clk_i);
    instr_i <= {1'b1, op, lit, bs};
    mem_rd_i <= rd;
    @(posedge clk_i);
    instr_i.valid <= 1'b0;
    #1;
    chk1(discard_o, sk);
    chk1(busy_o, sk);
    chk1(mem_we_o, we);
    if (we) chk8(mem_wd_o, wd);
    chk8(accumulator_reg_o, ea);
    chk8({4'h0, overflow_flag_o, zero_flag_o, aux_carry_flag_o, carry_flag_o}, {4'h0, ef});
  endtask

  // skip ops at the zero and wrap boundaries
  task automatic t_skip;
    ef = 4'h0;
    exec(MALU_DEC_ACC_SKZ, 8'h01, 8'h00, 3'h0, 1, 0, 8'h00, 8'h00);
    exec(MALU_DEC_ACC_SKZ, 8'h00, 8'h00, 3'h0, 0, 0, 8'h00, 8'hff);
    exec(MALU_INC_SKZ, 8'hff, 8'h00, 3'h0, 1, 1, 8'h00, 8'hff);
    exec(MALU_INC_SKZ, 8'h7f, 8'h00, 3'h0, 0, 1, 8'h80, 8'hff);
    exec(MALU_INC_ACC_SKZ, 8'hff, 8'h00, 3'h0, 1, 0, 8'h00, 8'h00);
    exec(MALU_MOVE_ACC_SKZ, 8'h44, 8'h00, 3'h0, 0, 0, 8'h00, 8'h44);
    exec(MALU_MOVE_ACC_SKZ, 8'h00, 8'h00, 3'h0, 1, 0, 8'h00, 8'h00);
    exec(MALU_SKIP_ZERO, 8'h00, 8'h00, 3'h0, 1, 0, 8'h00, 8'h00);
    exec(MALU_SKIP_ZERO, 8'h01, 8'h00, 3'h0, 0, 0, 8'h00, 8'h00);
    exec(MALU_SKIP_BIT_NZ, 8'h08, 8'h00, 3'h3, 1, 0, 8'h00, 8'h00);
    exec(MALU_SKIP_BIT_NZ, 8'h08, 8'h00, 3'h2, 0, 0, 8'h00, 8'h00);
    exec(MALU_SKIP_BIT_Z, 8'h08, 8'h00, 3'h3, 0, 0, 8'h00, 8'h00);
    exec(MALU_SKIP_BIT_Z, 8'h08, 8'h00, 3'h4, 1, 0, 8'h00, 8'h00);
  endtask

  // byte and bit set, subtract with flags, swaps
  task automatic t_arith;
    exec(MALU_SET_BYTE, 8'h12, 8'h00, 3'h0, 0, 1, 8'hff, 8'h00);
    exec(MALU_SET_BIT, 8'h0a, 8'h00, 3'h5, 0, 1, 8'h2a, 8'h00);
    exec(MALU_XOR_IMM, 8'h00, 8'h50, 3'h0, 0, 0, 8'h00, 8'h50);
    ef = 4'h3;
    exec(MALU_SUB_MEM, 8'h30, 8'h00, 3'h0, 0, 0, 8'h00, 8'h20);
    ef = 4'ha;
    exec(MALU_SUB_TO_MEM, 8'ha0, 8'h00, 3'h0, 0, 1, 8'h80, 8'h20);
    ef = 4'h7;
    exec(MALU_SUB_IMM, 8'h00, 8'h20, 3'h0, 0, 0, 8'h00, 8'h00);
    exec(MALU_SWAP, 8'h3c, 8'h00, 3'h0, 0, 1, 8'hc3, 8'h00);
    exec(MALU_SWAP_ACC, 8'h12, 8'h00, 3'h0, 0, 0, 8'h00, 8'h21);
  endtask

  // xor forms touch only the zero flag
  task automatic t_xor;
    exec(MALU_XOR_MEM, 8'h21, 8'h00, 3'h0, 0, 0, 8'h00, 8'h00);
    ef = 4'h3;
    exec(MALU_XOR_TO_MEM, 8'h0f, 8'h00, 3'h0, 0, 1, 8'h0f, 8'h00);
    exec(MALU_XOR_IMM, 8'h00, 8'hff, 3'h0, 0, 0, 8'h00, 8'hff);
  endtask

  // table read: fetch address, then low byte to memory and high part to latch
  task automatic tab(input malu_op_t op, input logic [2:0] pg);
    int n;
    @(posedge clk_i);
    instr_i <= {1'b1, op, 8'h00, 3'h0};
    @(posedge clk_i);
    instr_i.valid <= 1'b0;
    #1;
    chk1(rom_re_o, 1'b1);
    chk1(busy_o, 1'b1);
    chk8(rom_addr_o[7:0], 8'h9c);
    chk8({5'h0, rom_addr_o[10:8]}, {5'h0, pg});
    n = 0;
    while (mem_we_o !== 1'b1 && n < 4) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    chk1(mem_we_o, 1'b1);
    chk8(mem_wd_o, 8'h7e);
    chk8({2'b00, table_high_latch_o}, 8'h2b);
  endtask

  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // clock generation
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  // watchdog
  initial begin
    #(40 * 3000);
    n_mismatch++;
    final_report();
  end

  // main sequence
  initial begin
    n_mismatch = 0;
    n_compared = 0;
    rst_i = 1'b1;
    instr_i = '0;
    mem_rd_i = 8'h00;
    ef = 4'h0;
    ptr_v = 8'h9c;
    pc_v = 11'h5a3;
    rom_v = 14'h2b7e;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    t_skip();
    t_arith();
    t_xor();
    tab(MALU_TAB_CUR, 3'h5);
    tab(MALU_TAB_LAST, LAST_PAGE);
    repeat (2) @(posedge clk_i);
    final_report();
  end
endmodule
